// ---- logic/pcc_pkg.sv ----
// Package with offsets, field layout, reset values and frequency limits
package pcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REFKHZ = 8'h04;
  localparam logic [7:0] OFF_DDRKHZ = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_VCOKHZ = 8'h10;
  localparam logic [7:0] OFF_COREKHZ = 8'h14;

  // Control register field positions
  localparam int POS_DIV = 0;
  localparam int POS_MULT = 4;
  localparam int POS_RANGE = 12;
  localparam int POS_SEL = 16;
  localparam int POS_DDREN = 20;

  // Field widths
  localparam int DIV_W = 4;
  localparam int MULT_W = 6;
  localparam int FREQ_W = 24;

  // Status register bit positions
  localparam int ST_DIVFIELD = 0;
  localparam int ST_REFRANGE = 1;
  localparam int ST_DIVIN = 2;
  localparam int ST_LOOP = 3;
  localparam int ST_VCO = 4;
  localparam int ST_CORE = 5;
  localparam int ST_BUS = 6;
  localparam int ST_OUTCLK = 7;
  localparam int ST_DDR = 8;
  localparam int ST_SWITCHING = 9;
  localparam int ST_FACTOR = 12;

  // Values after reset
  localparam logic [DIV_W-1:0] RST_DIV = 4'h0;
  localparam logic [MULT_W-1:0] RST_MULT = 6'h00;
  localparam logic RST_RANGE = 1'b1;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic RST_DDREN = 1'b0;
  localparam logic [FREQ_W-1:0] RST_REFKHZ = 24'h004E20;
  localparam logic [FREQ_W-1:0] RST_DDRKHZ = 24'h024A10;

  // Core source select codes
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_HALF = 2'h1;
  localparam logic [1:0] SEL_VCO = 2'h3;

  // Legal setting and frequency limits in kHz
  localparam logic [DIV_W-1:0] DIV_MAX = 4'h9;
  localparam logic [FREQ_W-1:0] REF_MIN_KHZ = 24'd10000;
  localparam logic [FREQ_W-1:0] REF_MAX_KHZ = 24'd100000;
  localparam logic [FREQ_W-1:0] DIVIN_MIN_KHZ = 24'd10000;
  localparam logic [FREQ_W-1:0] DIVIN_MAX_KHZ = 24'd25000;
  localparam logic [FREQ_W-1:0] LOOP_MIN_KHZ = 24'd266000;
  localparam logic [FREQ_W-1:0] LOOP_MAX_KHZ = 24'd532000;
  localparam logic [FREQ_W-1:0] VCO_LO_MIN_KHZ = 24'd133000;
  localparam logic [FREQ_W-1:0] VCO_LO_MAX_KHZ = 24'd266000;
  localparam logic [FREQ_W-1:0] CORE_MAX_KHZ = 24'd300000;
  localparam logic [FREQ_W-1:0] BUS_MAX_KHZ = 24'd150000;
  localparam logic [FREQ_W-1:0] OUTCLK_MAX_KHZ = 24'd75000;
  localparam logic [FREQ_W-1:0] DDR_MIN_KHZ = 24'd83000;

  // Gap count loaded on entering GAP; the switch stays in GAP for this value plus one cycles
  localparam logic [3:0] SWITCH_GAP_CYC = 4'h2;

  // Frequency divided by a small factor
  function automatic logic [FREQ_W-1:0] pcc_div(input logic [FREQ_W-1:0] f,
                                                input logic [4:0] n);
    pcc_div = (n == 5'h00) ? f : f / {19'h00000, n};
  endfunction

  // Inclusive range test
  function automatic logic pcc_outside(input logic [FREQ_W-1:0] f,
                                       input logic [FREQ_W-1:0] lo,
                                       input logic [FREQ_W-1:0] hi);
    pcc_outside = (f < lo) || (f > hi);
  endfunction
endpackage

// ---- logic/pcc_ref_divider.sv ----
// Reference clock divider feeding the loop multiplier
module pcc_ref_divider #(
  parameter int DIV_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filtered reference level and its rising edge
  input wire logic refLevel,
  input wire logic refRise,
  // Divide field, factor is field plus one
  input wire logic [DIV_W-1:0] divField,
  // Divided reference
  output logic divClk
);
  import pcc_pkg::*;

  // Counter width the logic can serve
  if (DIV_W < 1 || DIV_W > 8) begin : gWidth
    $error("divide field width unsupported");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic divClk_d;
  logic wrap;
  logic [DIV_W:0] highLen;

  // Count reference edges over one divided period
  assign wrap = (cnt_q >= divField);
  assign cnt_d = refRise ? (wrap ? '0 : cnt_q + 1'b1) : cnt_q;
  assign highLen = ({1'b0, divField} + 1'b1) >> 1;
  assign divClk_d = (divField == '0) ? refLevel : ({1'b0, cnt_q} < highLen); // [R01]

  // Counter and output flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      divClk <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      divClk <= divClk_d;
    end
  end
endmodule

// ---- logic/pcc_clock_switch.sv ----
// Glitch-free selector for the core clock
module pcc_clock_switch (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Candidate clock levels: reference, half oscillator, oscillator
  input wire logic [2:0] srcLevel,
  input wire logic [1:0] wantIdx,
  // Switched clock and busy flag
  output logic coreClk,
  output logic switching
);
  import pcc_pkg::*;

  typedef enum logic [1:0] {RUN, DRAIN, GAP, ARM} pcc_sw_t;
  pcc_sw_t state_q;
  pcc_sw_t state_d;
  logic [1:0] cur_q;
  logic [1:0] cur_d;
  logic [3:0] gap_q;
  logic [3:0] gap_d;
  logic curLvl;
  logic newLvl;
  logic coreClk_d;

  assign curLvl = srcLevel[cur_q];
  assign newLvl = srcLevel[wantIdx];

  // Stop the old source low, pause, restart on the new one low
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    gap_d = gap_q;
    unique case (state_q)
      RUN: if (wantIdx != cur_q) state_d = DRAIN;
      DRAIN: if (!curLvl) begin
        state_d = GAP;
        gap_d = SWITCH_GAP_CYC;
      end
      GAP: if (gap_q == 4'h0) state_d = ARM;
        else gap_d = gap_q - 4'h1;
      ARM: if (!newLvl) begin
        cur_d = wantIdx;
        state_d = RUN;
      end
    endcase
  end

  // Output follows the source while running, keeps a high phase until the source falls while draining, else low
  assign coreClk_d = (state_q == RUN) ? curLvl :
                     (state_q == DRAIN) ? (curLvl & coreClk) : 1'b0; // [R13]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= RUN;
      cur_q <= 2'h0;
      gap_q <= 4'h0;
      coreClk <= 1'b0;
      switching <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      gap_q <= gap_d;
      coreClk <= coreClk_d;
      switching <= (state_d != RUN);
    end
  end
endmodule

// ---- logic/pcc_top.sv ----
// Clock control block: APB registers, divider, range checks, core clock select
// Functional notes
// R01: Reference divided by divide field plus one feeds the multiplier.
// R02: Divided reference times multiply field plus one gives loop frequency.
// R03: Range bit set: oscillator equals loop; clear: half of loop.
// R04: Source select picks reference, oscillator, or half oscillator for core.
// R05: Loop-to-core factor: select 11 gives 1 or 2; 01 gives 2 or 4.
// R06: Software keeps multiplier input between 10 and 25 MHz.
// R07: Software keeps multiplier output between 266 and 532 MHz.
// R08: Divide field only 0x00 to 0x09; reference within matching range.
// R09: Oscillator 266-532 MHz with range set, 133-266 MHz clear.
// R10: Core clock never above 300 MHz.
// R11: Bus clock at most 150 MHz, output clock at most 75 MHz.
// R12: With DDR, core between twice lowest and highest memory clock.
// R13: Source changes switch the core clock without runts or glitches.
//
// The register offsets and register access over APB were left to the implementer.
module pcc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins
  input wire logic refClkPin,
  input wire logic vcoClkPin,
  // Settings to the oscillator loop
  output logic divRefClk,
  output logic [pcc_pkg::MULT_W-1:0] loopMultiply,
  output logic vcoRange,
  // Generated clocks
  output logic coreClk,
  output logic busClk,
  output logic extOutClk
);
  import pcc_pkg::*;

  // Refuse package settings that the fixed-width arithmetic cannot serve
  if (DIV_W != 4) begin : gDivWidth
    $error("divide field must be four bits wide");
  end
  if (FREQ_W != 24) begin : gFreqWidth
    $error("frequency words must be 24 bits wide");
  end
  if (POS_MULT + MULT_W > POS_RANGE) begin : gMultField
    $error("multiply field runs into the range bit");
  end
  if (POS_SEL + 2 > POS_DDREN) begin : gSelField
    $error("source select field runs into the memory enable bit");
  end
  if (RST_DDRKHZ < DDR_MIN_KHZ) begin : gDdrReset
    $error("memory limit after reset below the memory floor");
  end

  // Status layout must keep its fields apart
  if (ST_DDR >= ST_SWITCHING) begin : gFlagBits
    $error("limit flags run into the switching bit");
  end
  if (ST_SWITCHING >= ST_FACTOR || ST_FACTOR + 3 > 32) begin : gFactorBits
    $error("factor field misplaced in the status word");
  end

  // Configuration registers
  logic [DIV_W-1:0] inputDivide_q;
  logic [MULT_W-1:0] loopMultiply_q;
  logic vcoRange_q;
  logic [1:0] coreSourceSelect_q;
  logic ddrEnable_q;
  logic [FREQ_W-1:0] refKhz_q;
  logic [FREQ_W-1:0] ddrMaxKhz_q;

  // APB decode
  logic setupPhase;
  logic accessDone;
  logic wrEn;
  logic hitCtrl;
  logic hitRef;
  logic hitDdr;
  logic hitStatus;
  logic hitVco;
  logic hitCore;
  logic hitAny;
  logic [31:0] ctrlWord;
  logic [31:0] readMux;
  logic [31:0] statusWord;

  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign wrEn = accessDone && pwrite && !pslverr;
  assign hitCtrl = (paddr == OFF_CTRL);
  assign hitRef = (paddr == OFF_REFKHZ);
  assign hitDdr = (paddr == OFF_DDRKHZ);
  assign hitStatus = (paddr == OFF_STATUS);
  assign hitVco = (paddr == OFF_VCOKHZ);
  assign hitCore = (paddr == OFF_COREKHZ);
  assign hitAny = hitCtrl | hitRef | hitDdr | hitStatus | hitVco | hitCore;

  // Pin synchronisers, three stages each
  logic [2:0] refSync_q;
  logic [2:0] vcoSync_q;
  logic refLvl_q;
  logic vcoLvl_q;
  logic refLvlPrev_q;
  logic vcoLvlPrev_q;
  logic refRise;
  logic vcoRise;
  logic vcoHalf_q;
  logic refAgree;
  logic vcoAgree;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refSync_q <= 3'h0;
      vcoSync_q <= 3'h0;
    end else begin
      refSync_q <= {refSync_q[1:0], refClkPin};
      vcoSync_q <= {vcoSync_q[1:0], vcoClkPin};
    end
  end

  // Stages two and three agree on the pin level
  assign refAgree = (refSync_q[1] == refSync_q[2]);
  assign vcoAgree = (vcoSync_q[1] == vcoSync_q[2]);

  // Level taken once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refLvl_q <= 1'b0;
      vcoLvl_q <= 1'b0;
      refLvlPrev_q <= 1'b0;
      vcoLvlPrev_q <= 1'b0;
    end else begin
      if (refAgree) refLvl_q <= refSync_q[2];
      if (vcoAgree) vcoLvl_q <= vcoSync_q[2];
      refLvlPrev_q <= refLvl_q;
      vcoLvlPrev_q <= vcoLvl_q;
    end
  end

  assign refRise = refLvl_q && !refLvlPrev_q;
  assign vcoRise = vcoLvl_q && !vcoLvlPrev_q;

  // Half-rate oscillator by toggling on each rising edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) vcoHalf_q <= 1'b0;
    else if (vcoRise) vcoHalf_q <= !vcoHalf_q;
  end

  // Reference divider
  pcc_ref_divider #(.DIV_W(DIV_W)) refDivider (
    .clk(clk),
    .reset(reset),
    .refLevel(refLvl_q),
    .refRise(refRise),
    .divField(inputDivide_q),
    .divClk(divRefClk)
  );

  // Core source index: 0 reference, 1 half oscillator, 2 oscillator
  logic [1:0] wantIdx;
  logic switching;
  assign wantIdx = (coreSourceSelect_q == SEL_VCO) ? 2'h2 :
                   (coreSourceSelect_q == SEL_HALF) ? 2'h1 : 2'h0; // [R04]

  pcc_clock_switch coreSwitch (
    .clk(clk),
    .reset(reset),
    .srcLevel({vcoLvl_q, vcoHalf_q, refLvl_q}),
    .wantIdx(wantIdx),
    .coreClk(coreClk),
    .switching(switching)
  );

  // Bus clock at half and output clock at quarter of the core clock
  logic coreClkPrev_q;
  logic [1:0] coreDiv_q;
  logic coreRise;
  assign coreRise = coreClk && !coreClkPrev_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      coreClkPrev_q <= 1'b0;
      coreDiv_q <= 2'h0;
    end else begin
      coreClkPrev_q <= coreClk;
      if (coreRise) coreDiv_q <= coreDiv_q + 2'h1;
    end
  end
  assign busClk = coreDiv_q[0];
  assign extOutClk = coreDiv_q[1];

  // Frequency chain in kHz
  logic [FREQ_W-1:0] divInKhz;
  logic [FREQ_W+MULT_W:0] loopWide;
  logic [FREQ_W-1:0] loopKhz;
  logic [FREQ_W-1:0] vcoKhz;
  logic [FREQ_W-1:0] coreKhz;
  logic [2:0] loopToCore;
  logic loopSat;
  logic [4:0] divFactor;

  assign divFactor = 5'({1'b0, inputDivide_q} + 5'h01); // [R01]
  assign divInKhz = pcc_div(refKhz_q, divFactor); // [R01]
  assign loopWide = divInKhz * ({1'b0, loopMultiply_q} + 7'h01); // [R02]
  assign loopSat = |loopWide[FREQ_W+MULT_W:FREQ_W];
  assign loopKhz = loopSat ? {FREQ_W{1'b1}} : loopWide[FREQ_W-1:0];
  assign vcoKhz = vcoRange_q ? loopKhz : pcc_div(loopKhz, 5'h02); // [R03]
  assign coreKhz = (coreSourceSelect_q == SEL_VCO) ? vcoKhz :
                   (coreSourceSelect_q == SEL_HALF) ? pcc_div(vcoKhz, 5'h02) :
                   refKhz_q; // [R04]
  // Total loop-to-core division, zero when the reference is used
  assign loopToCore = (coreSourceSelect_q == SEL_VCO) ? (vcoRange_q ? 3'h1 : 3'h2) :
                      (coreSourceSelect_q == SEL_HALF) ? (vcoRange_q ? 3'h2 : 3'h4) :
                      3'h0; // [R05]

  // Range checks reported to software
  logic [8:0] flags;
  logic refOut;
  logic [FREQ_W-1:0] refMinForDiv;
  assign refMinForDiv = DIVIN_MIN_KHZ * ({20'h00000, inputDivide_q} + 24'h1);
  assign refOut = pcc_outside(refKhz_q, refMinForDiv, REF_MAX_KHZ) ||
                  (refKhz_q < REF_MIN_KHZ);
  assign flags[ST_DIVFIELD] = (inputDivide_q > DIV_MAX); // [R08]
  assign flags[ST_REFRANGE] = refOut; // [R08]
  assign flags[ST_DIVIN] = pcc_outside(divInKhz, DIVIN_MIN_KHZ, DIVIN_MAX_KHZ); // [R06]
  assign flags[ST_LOOP] = pcc_outside(loopKhz, LOOP_MIN_KHZ, LOOP_MAX_KHZ); // [R07]
  assign flags[ST_VCO] = vcoRange_q ? pcc_outside(vcoKhz, LOOP_MIN_KHZ, LOOP_MAX_KHZ) :
                         pcc_outside(vcoKhz, VCO_LO_MIN_KHZ, VCO_LO_MAX_KHZ); // [R09]
  assign flags[ST_CORE] = (coreKhz > CORE_MAX_KHZ); // [R10]
  assign flags[ST_BUS] = (pcc_div(coreKhz, 5'h02) > BUS_MAX_KHZ); // [R11]
  assign flags[ST_OUTCLK] = (pcc_div(coreKhz, 5'h04) > OUTCLK_MAX_KHZ); // [R11]
  assign flags[ST_DDR] = ddrEnable_q &&
                         pcc_outside(coreKhz, 24'(DDR_MIN_KHZ << 1),
                                     24'(ddrMaxKhz_q << 1)); // [R12]

  // Read data selection
  assign ctrlWord = 32'(inputDivide_q) << POS_DIV | 32'(loopMultiply_q) << POS_MULT |
                    32'(vcoRange_q) << POS_RANGE | 32'(coreSourceSelect_q) << POS_SEL |
                    32'(ddrEnable_q) << POS_DDREN;
  // Status word: limit flags, switch busy, loop-to-core factor
  assign statusWord = 32'(flags) | 32'(switching) << ST_SWITCHING |
                      32'(loopToCore) << ST_FACTOR;
  assign readMux = hitCtrl ? ctrlWord :
                   hitRef ? {8'h00, refKhz_q} :
                   hitDdr ? {8'h00, ddrMaxKhz_q} :
                   hitStatus ? statusWord :
                   hitVco ? {8'h00, vcoKhz} :
                   hitCore ? {8'h00, coreKhz} : 32'h00000000;

  // APB answer: one access cycle after setup, error on unmapped address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !hitAny;
      if (setupPhase) prdata <= pwrite ? 32'h00000000 : readMux;
    end
  end

  // Control register write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inputDivide_q <= RST_DIV;
      loopMultiply_q <= RST_MULT;
      vcoRange_q <= RST_RANGE;
      coreSourceSelect_q <= RST_SEL;
      ddrEnable_q <= RST_DDREN;
    end else if (wrEn && hitCtrl) begin
      inputDivide_q <= pwdata[POS_DIV +: DIV_W];
      loopMultiply_q <= pwdata[POS_MULT +: MULT_W];
      vcoRange_q <= pwdata[POS_RANGE];
      coreSourceSelect_q <= pwdata[POS_SEL +: 2];
      ddrEnable_q <= pwdata[POS_DDREN];
    end
  end

  // Reference and memory frequency registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refKhz_q <= RST_REFKHZ;
      ddrMaxKhz_q <= RST_DDRKHZ;
    end else begin
      if (wrEn && hitRef) refKhz_q <= pwdata[FREQ_W-1:0];
      if (wrEn && hitDdr) ddrMaxKhz_q <= pwdata[FREQ_W-1:0];
    end
  end

  // Loop settings out to the oscillator
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loopMultiply <= RST_MULT;
      vcoRange <= RST_RANGE;
    end else begin
      loopMultiply <= loopMultiply_q; // [R02]
      vcoRange <= vcoRange_q; // [R03]
    end
  end
endmodule

// ---- verification/pcc_top_properties.sv ----
// Port checker for the clock control block
module pcc_top_properties (
  // Clock and reset
  input logic clk,
  input logic reset,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Clock pins
  input logic refClkPin,
  input logic vcoClkPin,
  // Loop settings
  input logic divRefClk,
  input logic [pcc_pkg::MULT_W-1:0] loopMultiply,
  input logic vcoRange,
  // Generated clocks
  input logic coreClk,
  input logic busClk,
  input logic extOutClk
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Accepted write to the control word
  wire ctrlWr = psel && penable && pready && pwrite && paddr == OFF_CTRL && !pslverr;

  // Bus handshake and the copies of the control fields
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  AST_MULT_COPY: assert property (ctrlWr |=> (loopMultiply == $past(pwdata[9:4]))
    or ##1 (loopMultiply == $past(pwdata[9:4], 2)))
    else $error("multiply field not passed on");
  AST_RANGE_COPY: assert property (ctrlWr |=> (vcoRange == $past(pwdata[12]))
    or ##1 (vcoRange == $past(pwdata[12], 2)))
    else $error("range bit not passed on");
  AST_RESET_STATE: assert property ($past(reset) |->
    loopMultiply == 6'h00 && vcoRange && !coreClk && !pready)
    else $error("state after reset wrong");
  // No runt phases on the core clock; bus clock moves only after the core clock was high
  AST_HIGH_MIN: assert property ($rose(coreClk) |=> coreClk)
    else $error("core clock high runt");
  AST_LOW_MIN: assert property ($fell(coreClk) |=> !coreClk)
    else $error("core clock low runt");
  AST_BUS_HALF: assert property ($changed(busClk) |->
    $past(coreClk) || $past(coreClk, 2))
    else $error("bus clock moved without core edge");
endmodule

// ---- verification/pcc_top_tb.sv ----
// Self-checking bench for the clock control block
module pcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic refClkPin = 1'b0;
  logic vcoClkPin = 1'b0;
  logic divRefClk;
  logic [MULT_W-1:0] loopMultiply;
  logic vcoRange;
  logic coreClk;
  logic busClk;
  logic extOutClk;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int refCnt = 0;
  int vcoCnt = 0;
  wire [3:0] probe = {extOutClk, busClk, coreClk, divRefClk};

  pcc_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refClkPin(refClkPin), .vcoClkPin(vcoClkPin), .divRefClk(divRefClk),
    .loopMultiply(loopMultiply), .vcoRange(vcoRange), .coreClk(coreClk),
    .busClk(busClk), .extOutClk(extOutClk));

  // Clock, reset release and hang limit
  always #10 clk = ~clk;
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // Pin clocks: reference period 24 cycles, oscillator period 8 cycles
  always @(posedge clk) begin
    refCnt <= (refCnt == 11) ? 0 : refCnt + 1;
    vcoCnt <= (vcoCnt == 3) ? 0 : vcoCnt + 1;
    if (refCnt == 11) refClkPin <= ~refClkPin;
    if (vcoCnt == 3) vcoClkPin <= ~vcoClkPin;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
  endtask

  // Program reference and control word, then let the switch settle
  task automatic cfg(input int rf, input int dv, input int ml, input int rg, input int sl,
                     input int dd);
    wr(OFF_REFKHZ, rf);
    wr(OFF_CTRL, (dd << POS_DDREN) | (sl << POS_SEL) | (rg << POS_RANGE) | (ml << POS_MULT)
      | dv);
    repeat (80) @(posedge clk);
  endtask

  // Cycles between two rising edges of a probed clock
  task automatic per(input int i, output int p);
    int n;
    int t;
    n = 0;
    t = 0;
    for (int k = 0; k < 4; k++) begin
      while (probe[i] !== k[0] && n < 400) begin
        @(posedge clk);
        n++;
      end
      if (k == 1) t = n;
    end
    p = n - t;
  endtask

  task automatic t_reset();
    logic [31:0] r;
    rdv(OFF_CTRL, r);
    check(r, 32'h00001000);
    rdv(OFF_REFKHZ, r);
    check(r, {8'h00, RST_REFKHZ});
    rdv(OFF_DDRKHZ, r);
    check(r, {8'h00, RST_DDRKHZ});
    rdv(OFF_STATUS, r);
    check(r, 32'h00000018);
    $display("reset values done");
  endtask

  // Computed oscillator and core frequency for one setting
  task automatic comp(input int rf, input int dv, input int ml, input int rg, input int sl);
    logic [31:0] r;
    int loopF;
    int vco;
    loopF = (rf / (dv + 1)) * (ml + 1);
    vco = rg ? loopF : loopF / 2;
    cfg(rf, dv, ml, rg, sl, 0);
    rdv(OFF_VCOKHZ, r);
    check(r, vco);
    rdv(OFF_COREKHZ, r);
    check(r, sl == 3 ? vco : sl == 1 ? vco / 2 : rf);
    rdv(OFF_STATUS, r);
    check(r[14:12], sl == 3 ? (rg ? 1 : 2) : sl == 1 ? (rg ? 2 : 4) : 0);
    check(loopMultiply, ml);
    check(vcoRange, rg);
  endtask

  task automatic t_comp();
    comp(20000, 0, 19, 1, 3);
    comp(50000, 1, 15, 0, 1);
    comp(30000, 2, 26, 1, 1);
    comp(100000, 9, 31, 0, 3);
    comp(20000, 0, 19, 0, 2);
    $display("frequency computation done");
  endtask

  task automatic t_flags();
    logic [31:0] r;
    cfg(20000, 0, 19, 1, 3, 0);
    rdv(OFF_STATUS, r);
    check(r, 32'h000010E0);
    cfg(20000, 0, 9, 1, 3, 0);
    rdv(OFF_STATUS, r);
    check(r, 32'h00001018);
    cfg(20000, 10, 0, 1, 0, 0);
    rdv(OFF_STATUS, r);
    check(r, 32'h0000001F);
    cfg(20000, 0, 14, 1, 1, 1);
    rdv(OFF_STATUS, r);
    check(r, 32'h00002100);
    $display("limit flags done");
  endtask

  task automatic t_clk();
    int p;
    logic [31:0] r;
    cfg(20000, 2, 26, 1, 3, 0);
    per(1, p);
    check(p, 8);
    per(2, p);
    check(p, 16);
    per(3, p);
    check(p, 32);
    per(0, p);
    check(p, 72);
    cfg(20000, 2, 26, 1, 1, 0);
    per(1, p);
    check(p, 16);
    cfg(20000, 2, 26, 1, 0, 0);
    per(1, p);
    check(p, 24);
    wr(OFF_CTRL, (3 << POS_SEL) | (1 << POS_RANGE) | (26 << POS_MULT) | 2);
    rdv(OFF_STATUS, r);
    check(r[ST_SWITCHING], 1'b1);
    $display("clock outputs done");
  endtask

  task automatic t_bus();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h20, 32'h00000000, r, e);
    check(e, 1'b1);
    check(r, 32'h00000000);
    apb(1'b1, 8'h20, 32'hFFFFFFFF, r, e);
    check(e, 1'b1);
    apb(1'b1, OFF_VCOKHZ, 32'h00123456, r, e);
    check(e, 1'b0);
    rdv(OFF_VCOKHZ, r);
    check(r, (20000 / 3) * 27);
    $display("bus responses done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    @(negedge reset);
    repeat (20) @(posedge clk);
    t_reset();
    t_comp();
    t_flags();
    t_clk();
    t_bus();
    end_of_test();
  end
endmodule

bind pcc_top pcc_top_properties u_props (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .refClkPin(refClkPin), .vcoClkPin(vcoClkPin),
  .divRefClk(divRefClk), .loopMultiply(loopMultiply), .vcoRange(vcoRange),
  .coreClk(coreClk), .busClk(busClk), .extOutClk(extOutClk));
